// ### rtl/plp_pkg.sv
// Constants, tables and carriers for the per-port link and 100BASE-X coding block.
// Assumes a 200 MHz system clock; all times are turned into cycles here.
package plp_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_KHZ = 200000;
  localparam int LOCK_MS = 50;
  localparam int LOCK_CYC = LOCK_MS * CLK_KHZ;
  localparam int WIN_MS = 2;
  localparam int WIN_CYC = WIN_MS * CLK_KHZ;
  localparam int NLP_MS = 16;
  localparam int NLP_CYC = NLP_MS * CLK_KHZ;
  localparam int L10_MS = 150;
  localparam int L10_CYC = L10_MS * CLK_KHZ;
  localparam int CW = 25;
  localparam logic [3:0] IDLE_RUN = 4'hC;
  localparam logic [4:0] FAR_END_FAULT_PATTERN_LAST = 5'h10;
  localparam logic [1:0] FAR_END_FAULT_PATTERN_REPS = 2'h3;
  // ----------------------------------------
  // Register map (index, byte address is index * 4)
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h01;
  localparam logic [7:0] REG_ADV = 8'h04;
  localparam logic [7:0] REG_LPA = 8'h05;
  localparam logic [7:0] REG_CFG = 8'h10;
  localparam logic [7:0] REG_PST = 8'h11;
  localparam int CTRL_LOOP = 14;
  localparam int CTRL_SPD = 13;
  localparam int CTRL_AN_EN = 12;
  localparam int CTRL_FDX = 8;
  localparam int STAT_RF = 4;
  localparam int STAT_LINK = 2;
  localparam int ADV_RF = 13;
  localparam int LPA_RF = 13;
  localparam int CFG_FORCE = 14;
  localparam int CFG_SCR_BYP = 12;
  localparam int CFG_FAR_END_FAULT_PATTERN_EN = 2;
  localparam logic [15:0] CTRL_RST = 16'h3000;
  localparam logic [15:0] ADV_RST = 16'h01E1;
  localparam logic [10:0] LFSR_SEED = 11'h7FF;
  // ----------------------------------------
  // Code groups
  // ----------------------------------------
  localparam logic [4:0] SYM_IDLE = 5'h1F;
  localparam logic [4:0] SYM_J = 5'h18;
  localparam logic [4:0] SYM_K = 5'h11;
  localparam logic [4:0] SYM_T = 5'h0D;
  localparam logic [4:0] SYM_R = 5'h07;
  localparam logic [4:0] SYM_NONE = 5'h00;
  localparam logic [4:0] SYM_FAR_END_FAULT_PATTERN_ONES = 5'h1F;
  localparam logic [4:0] SYM_FAR_END_FAULT_PATTERN_END = 5'h1E;
  localparam logic [3:0] NIB_PRE = 4'h5;
  localparam logic [79:0] ENC_TBL = {5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17, 5'h16, 5'h13, 5'h12,
                                     5'h0F, 5'h0E, 5'h0B, 5'h0A, 5'h15, 5'h14, 5'h09, 5'h1E};

  typedef enum logic [2:0] {
    PLP_TX_IDLE = 3'b000,
    PLP_TX_K = 3'b001,
    PLP_TX_DATA = 3'b010,
    PLP_TX_R = 3'b011,
    PLP_TX_FAR_END_FAULT_PATTERN = 3'b100
  } plp_tx_e;

  typedef struct packed {
    logic en;
    logic [3:0] d;
  } plp_mii_tx_s;

  typedef struct packed {
    logic dv;
    logic er;
    logic crs;
    logic [3:0] d;
  } plp_mii_rx_s;

  function automatic logic [4:0] plp_enc(input logic [3:0] n);
    return ENC_TBL[5 * n +: 5];
  endfunction : plp_enc

  function automatic logic [3:0] plp_dec(input logic [4:0] s);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (ENC_TBL[5 * i +: 5] == s) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : plp_dec

  // Five steps of x^11 + x^9 + 1; returns {next state, key}
  function automatic logic [15:0] plp_scr5(input logic [10:0] l);
    logic [10:0] s;
    logic [4:0] k;
    logic fb;
    s = l;
    k = 5'h00;
    for (int i = 0; i < 5; i++) begin
      fb = s[10] ^ s[8];
      s = {s[9:0], fb};
      k[i] = fb;
    end
    return {s, k};
  endfunction : plp_scr5
endpackage : plp_pkg

// ### rtl/plp_link_pcs.sv
// Per-port link criteria, parallel detection, fault handling and 100BASE-X PCS.
// Assumes one 200 MHz clock, one symbol or nibble per cycle, and an Avalon-MM master.
//
// Function
// RL1: Software waits up to 300 us after reset before configuring negotiation.
// RL2: Software writes advertisement bits first, then sets negotiation enable.
// RL3: 100 Mbps link comes up after descrambler lock held for 50 ms.
// RL4: 100 Mbps link drops if a 2 ms window lacks 12 consecutive IDLEs.
// RL5: 100 Mbps idles alone never bring up the 10 Mbps link.
// RL6: During negotiation, link pulses or IDLEs select the matching speed.
// RL7: A parallel-detected link always runs half duplex.
// RL8: At 10 Mbps the idle line carries periodic link pulses.
// RL9: Fiber mode taken from the select pin only when reset completes.
// RL10: Received remote fault sets partner bit 13 and status bit 4.
// RL11: Advertisement bit 13 sends the local remote fault in the base page.
// RL12: In fiber mode a signal-detect fault blocks receive data and drops link.
// RL13: Far-end fault pattern is 84 ones then one zero, repeated.
// RL14: Send the pattern at least three times under the four fault conditions; the code uses only fiber signal-detect loss and PLL unlock.
// RL15: 100BASE-X sends 5-bit symbols, IDLE whenever the MAC is quiet.
// RL16: First two nibbles after transmit enable become J and K.
// RL17: End of packet inserts T and R before IDLE.
// RL18: Received J and K are presented as two preamble nibbles.
// RL19: Twisted pair transmit is scrambled; receive is descrambled before decoding.
// RL20: One to four dribble bits give a ones-padded nibble; five to seven none.
// RL21: At 10 Mbps the block encoder is bypassed.
// RL22: Fiber symbols go out as NRZI, without MLT-3.
// RL23: Forced link pass lets packets go out while link is down.
// RL24: Transmit nibble and enable are sampled on the rising clock edge.
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module plp_link_pcs #(
  parameter int LOCK_CYC = plp_pkg::LOCK_CYC,
  parameter int WIN_CYC = plp_pkg::WIN_CYC,
  parameter int NLP_CYC = plp_pkg::NLP_CYC,
  parameter int L10_CYC = plp_pkg::L10_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire plp_pkg::plp_mii_tx_s i_mii_tx,
  output plp_pkg::plp_mii_rx_s o_mii_rx,
  input wire logic i_fiber_select_pin_n,
  input wire logic i_signal_detect_input,
  input wire logic i_rx_pll_lock,
  input wire logic i_descr_lock,
  input wire logic i_nlp,
  input wire logic [4:0] i_rx_sym,
  input wire logic i_rx10_dv,
  input wire logic [2:0] i_rx_dribble,
  input wire logic [3:0] i_rx_tail,
  input wire logic [15:0] i_lp_page,
  input wire logic i_lp_page_valid,
  input wire logic i_an_link,
  input wire logic i_an_100,
  input wire logic i_an_fdx,
  output logic [4:0] o_tx_sym,
  output logic o_tx_nrzi,
  output logic o_tx_mlt3,
  output plp_pkg::plp_mii_tx_s o_tx10,
  output logic o_nlp_tx,
  output logic [15:0] o_adv_page,
  output logic o_link,
  output logic o_spd100,
  output logic o_fdx,
  output logic o_fiber
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [15:0] ctrl;
    logic [15:0] adv;
    logic [15:0] lpa;
    logic [15:0] cfg;
    logic rf;
    logic fib_done;
    logic fiber;
    logic spd100;
    logic fdx;
    logic pd;
    logic [plp_pkg::CW-1:0] lock_cnt;
    logic link100;
    logic [plp_pkg::CW-1:0] win_cnt;
    logic [3:0] run;
    logic seen;
    logic link10;
    logic [plp_pkg::CW-1:0] l10_cnt;
    logic [plp_pkg::CW-1:0] nlp_cnt;
    logic nlp_tx;
    plp_pkg::plp_tx_e tx_st;
    logic [4:0] tx_raw;
    logic [4:0] tx_sym;
    logic [4:0] fcnt;
    logic [1:0] reps;
    logic [10:0] tlfsr;
    logic [10:0] rlfsr;
    logic rx_frame;
    plp_pkg::plp_mii_rx_s rx;
    plp_pkg::plp_mii_tx_s tx10;
  } plp_st_s;

  plp_st_s st;
  plp_st_s next_st;
  logic req;
  logic sd_ok;
  logic fault;
  logic far_end_fault_pattern_cond;
  logic tx_ok;
  logic scr_on;
  logic [15:0] tkey;
  logic [15:0] rkey;
  logic [4:0] rs;
  logic [7:0] widx;

  assign req = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~st.ack;
  assign widx = {2'b00, i_avs_address[7:2]};
  assign sd_ok = ~st.fiber | i_signal_detect_input;
  assign fault = st.fiber & (~i_signal_detect_input | ~i_rx_pll_lock);
  assign far_end_fault_pattern_cond = fault & st.cfg[plp_pkg::CFG_FAR_END_FAULT_PATTERN_EN] & ~st.ctrl[plp_pkg::CTRL_LOOP]; // RL14
  assign tx_ok = (st.spd100 ? st.link100 : st.link10) | st.cfg[plp_pkg::CFG_FORCE]; // RL23
  assign scr_on = ~st.fiber & ~st.cfg[plp_pkg::CFG_SCR_BYP];
  assign tkey = plp_pkg::plp_scr5(st.tlfsr);
  assign rkey = plp_pkg::plp_scr5(st.rlfsr);
  // Blocked fiber data looks like IDLE, so no frame can start
  assign rs = ~sd_ok ? plp_pkg::SYM_IDLE : (scr_on ? i_rx_sym ^ rkey[4:0] : i_rx_sym); // RL12 RL19

  always_comb begin
    next_st = st;
    // ----------------------------------------
    // Register slave, one wait cycle per access
    // ----------------------------------------
    next_st.ack = req & ~st.ack;
    if (req & ~st.ack) begin
      case (widx)
        plp_pkg::REG_CTRL: next_st.rdata = {16'h0000, st.ctrl};
        plp_pkg::REG_STAT: next_st.rdata = {27'h0, st.rf, 1'b0, o_link, 2'b00};
        plp_pkg::REG_ADV: next_st.rdata = {16'h0000, st.adv};
        plp_pkg::REG_LPA: next_st.rdata = {16'h0000, st.lpa};
        plp_pkg::REG_CFG: next_st.rdata = {16'h0000, st.cfg};
        plp_pkg::REG_PST: next_st.rdata = {26'h0, st.link10, st.pd, st.fiber, st.fdx, st.spd100, st.link100};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
    if (i_avs_write & st.ack) begin
      case (widx)
        plp_pkg::REG_CTRL: next_st.ctrl = i_avs_writedata[15:0];
        plp_pkg::REG_ADV: next_st.adv = i_avs_writedata[15:0];
        plp_pkg::REG_CFG: next_st.cfg = i_avs_writedata[15:0];
        default: next_st.cfg = st.cfg;
      endcase
    end
    // Clear on read; a fault in the same cycle wins
    if (i_avs_read & st.ack & (widx == plp_pkg::REG_STAT)) begin
      next_st.rf = 1'b0;
    end
    if (i_lp_page_valid) begin
      next_st.lpa = i_lp_page; // RL10
    end
    if ((i_lp_page_valid & i_lp_page[plp_pkg::LPA_RF] & st.ctrl[plp_pkg::CTRL_AN_EN]) | fault) begin
      next_st.rf = 1'b1; // RL10
    end
    // ----------------------------------------
    // Fiber strap and speed resolution
    // ----------------------------------------
    if (~st.fib_done) begin
      next_st.fiber = ~i_fiber_select_pin_n; // RL9
      next_st.fib_done = 1'b1;
    end
    if (st.fiber) begin
      next_st.spd100 = 1'b1;
      next_st.fdx = st.ctrl[plp_pkg::CTRL_FDX];
      next_st.pd = 1'b0;
    end else if (~st.ctrl[plp_pkg::CTRL_AN_EN]) begin
      next_st.spd100 = st.ctrl[plp_pkg::CTRL_SPD];
      next_st.fdx = st.ctrl[plp_pkg::CTRL_FDX];
      next_st.pd = 1'b0;
    end else if (i_an_link) begin
      next_st.spd100 = i_an_100;
      next_st.fdx = i_an_fdx;
      next_st.pd = 1'b0;
    end else if (i_nlp) begin
      next_st.spd100 = 1'b0; // RL6
      next_st.fdx = 1'b0; // RL7
      next_st.pd = 1'b1;
    end else if (st.seen) begin
      next_st.spd100 = 1'b1; // RL6
      next_st.fdx = 1'b0; // RL7
      next_st.pd = 1'b1;
    end
    // ----------------------------------------
    // 100 Mbps link criteria
    // ----------------------------------------
    if (i_descr_lock & sd_ok) begin
      if (st.lock_cnt != plp_pkg::CW'(LOCK_CYC - 1)) begin
        next_st.lock_cnt = st.lock_cnt + 1'b1;
      end else begin
        next_st.link100 = 1'b1; // RL3
      end
    end else begin
      next_st.lock_cnt = '0;
    end
    next_st.run = (rs != plp_pkg::SYM_IDLE) ? 4'h0 : (st.run == plp_pkg::IDLE_RUN) ? st.run : st.run + 4'h1;
    if (next_st.run == plp_pkg::IDLE_RUN) begin
      next_st.seen = 1'b1;
    end
    if (st.win_cnt == plp_pkg::CW'(WIN_CYC - 1)) begin
      next_st.win_cnt = '0;
      next_st.seen = 1'b0;
      if (~st.seen) begin
        next_st.link100 = 1'b0; // RL4
      end
    end else begin
      next_st.win_cnt = st.win_cnt + 1'b1;
    end
    if (~sd_ok) begin
      next_st.link100 = 1'b0; // RL12
      next_st.lock_cnt = '0;
    end
    // ----------------------------------------
    // 10 Mbps link: only link pulses count, never 100 Mbps idles
    // ----------------------------------------
    if (i_nlp & ~st.fiber) begin
      next_st.link10 = 1'b1; // RL5
      next_st.l10_cnt = '0;
    end else if (st.l10_cnt == plp_pkg::CW'(L10_CYC - 1)) begin
      next_st.link10 = 1'b0;
    end else begin
      next_st.l10_cnt = st.l10_cnt + 1'b1;
    end
    // ----------------------------------------
    // 10 Mbps transmit: encoder bypassed, pulses while quiet
    // ----------------------------------------
    next_st.tx10.en = ~st.spd100 & i_mii_tx.en & tx_ok; // RL21 RL24
    next_st.tx10.d = st.spd100 ? 4'h0 : i_mii_tx.d;
    next_st.nlp_tx = 1'b0;
    if (st.spd100 | i_mii_tx.en) begin
      next_st.nlp_cnt = '0;
    end else if (st.nlp_cnt == plp_pkg::CW'(NLP_CYC - 1)) begin
      next_st.nlp_cnt = '0;
      next_st.nlp_tx = 1'b1; // RL8
    end else begin
      next_st.nlp_cnt = st.nlp_cnt + 1'b1;
    end
    // ----------------------------------------
    // 100BASE-X transmit
    // ----------------------------------------
    case (st.tx_st)
      plp_pkg::PLP_TX_IDLE: begin
        next_st.tx_raw = plp_pkg::SYM_IDLE; // RL15
        if (far_end_fault_pattern_cond) begin
          next_st.tx_st = plp_pkg::PLP_TX_FAR_END_FAULT_PATTERN;
          next_st.tx_raw = plp_pkg::SYM_FAR_END_FAULT_PATTERN_ONES;
          next_st.fcnt = 5'h01;
          next_st.reps = 2'h0;
        end else if (i_mii_tx.en & tx_ok) begin
          next_st.tx_raw = plp_pkg::SYM_J; // RL16
          next_st.tx_st = plp_pkg::PLP_TX_K;
        end
      end
      plp_pkg::PLP_TX_K: begin
        next_st.tx_raw = plp_pkg::SYM_K; // RL16
        next_st.tx_st = plp_pkg::PLP_TX_DATA;
      end
      plp_pkg::PLP_TX_DATA: begin
        if (i_mii_tx.en) begin
          next_st.tx_raw = plp_pkg::plp_enc(i_mii_tx.d); // RL24
        end else begin
          next_st.tx_raw = plp_pkg::SYM_T; // RL17
          next_st.tx_st = plp_pkg::PLP_TX_R;
        end
      end
      plp_pkg::PLP_TX_R: begin
        next_st.tx_raw = plp_pkg::SYM_R; // RL17
        next_st.tx_st = plp_pkg::PLP_TX_IDLE;
      end
      plp_pkg::PLP_TX_FAR_END_FAULT_PATTERN: begin
        // 17 symbols carry 84 ones and a closing zero
        next_st.tx_raw = (st.fcnt == plp_pkg::FAR_END_FAULT_PATTERN_LAST) ? plp_pkg::SYM_FAR_END_FAULT_PATTERN_END : plp_pkg::SYM_FAR_END_FAULT_PATTERN_ONES; // RL13
        next_st.fcnt = st.fcnt + 5'h01;
        if (st.fcnt == plp_pkg::FAR_END_FAULT_PATTERN_LAST) begin
          next_st.fcnt = 5'h00;
          if (st.reps != plp_pkg::FAR_END_FAULT_PATTERN_REPS) begin
            next_st.reps = st.reps + 2'h1;
          end
        end
        // Leave only at a pattern boundary after three full patterns
        if ((st.fcnt == 5'h00) & (st.reps == plp_pkg::FAR_END_FAULT_PATTERN_REPS) & ~far_end_fault_pattern_cond) begin
          next_st.tx_raw = plp_pkg::SYM_IDLE; // RL14
          next_st.tx_st = plp_pkg::PLP_TX_IDLE;
        end
      end
      default: begin
        next_st.tx_raw = plp_pkg::SYM_IDLE;
        next_st.tx_st = plp_pkg::PLP_TX_IDLE;
      end
    endcase
    next_st.tlfsr = tkey[15:5];
    next_st.rlfsr = rkey[15:5];
    if (~st.spd100) begin
      next_st.tx_sym = plp_pkg::SYM_NONE; // RL21
    end else begin
      next_st.tx_sym = scr_on ? next_st.tx_raw ^ tkey[4:0] : next_st.tx_raw; // RL19
    end
    // ----------------------------------------
    // Receive: 10 Mbps pass-through and 100BASE-X decoding
    // ----------------------------------------
    next_st.rx = '0;
    if (~st.spd100) begin
      next_st.rx.dv = i_rx10_dv & sd_ok;
      next_st.rx.crs = i_rx10_dv & sd_ok;
      next_st.rx.d = i_rx_sym[3:0];
    end else if (~st.rx_frame) begin
      if (rs == plp_pkg::SYM_J) begin
        next_st.rx_frame = 1'b1;
        next_st.rx = '{dv: 1'b1, er: 1'b0, crs: 1'b1, d: plp_pkg::NIB_PRE}; // RL18
      end
    end else if (rs == plp_pkg::SYM_K) begin
      next_st.rx = '{dv: 1'b1, er: 1'b0, crs: 1'b1, d: plp_pkg::NIB_PRE}; // RL18
    end else if (rs == plp_pkg::SYM_T) begin
      next_st.rx_frame = 1'b0;
      if ((i_rx_dribble != 3'h0) & (i_rx_dribble <= 3'h4)) begin
        next_st.rx.dv = 1'b1; // RL20
        next_st.rx.d = i_rx_tail | (4'hF << i_rx_dribble);
      end
    end else if (rs == plp_pkg::SYM_IDLE) begin
      next_st.rx_frame = 1'b0;
      next_st.rx.er = 1'b1;
    end else begin
      next_st.rx = '{dv: 1'b1, er: 1'b0, crs: 1'b1, d: plp_pkg::plp_dec(rs)}; // RL19
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '0;
      st.ctrl <= plp_pkg::CTRL_RST;
      st.adv <= plp_pkg::ADV_RST;
      st.spd100 <= 1'b1;
      st.tlfsr <= plp_pkg::LFSR_SEED;
      st.rlfsr <= plp_pkg::LFSR_SEED;
    end else begin
      st <= next_st;
    end
  end

  assign o_avs_readdata = st.rdata;
  assign o_tx_sym = st.tx_sym;
  assign o_tx_nrzi = st.fiber; // RL22
  assign o_tx_mlt3 = ~st.fiber & st.spd100;
  assign o_tx10 = st.tx10;
  assign o_nlp_tx = st.nlp_tx;
  assign o_adv_page = st.adv; // RL11
  assign o_link = sd_ok & (st.spd100 ? st.link100 : st.link10); // RL12
  assign o_spd100 = st.spd100;
  assign o_fdx = st.fdx;
  assign o_fiber = st.fiber;
  assign o_mii_rx = st.rx;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_TX_JK: assert property (@(posedge i_clk) disable iff (i_rst) // RL16
    st.tx_st == plp_pkg::PLP_TX_IDLE && !far_end_fault_pattern_cond && i_mii_tx.en && tx_ok
    |=> st.tx_raw == plp_pkg::SYM_J ##1 st.tx_raw == plp_pkg::SYM_K)
    else $error("start delimiter not sent");
  AST_TX_TR: assert property (@(posedge i_clk) disable iff (i_rst) // RL17
    st.tx_st == plp_pkg::PLP_TX_DATA && !i_mii_tx.en
    |=> st.tx_raw == plp_pkg::SYM_T ##1 st.tx_raw == plp_pkg::SYM_R && st.tx_st == plp_pkg::PLP_TX_IDLE)
    else $error("end delimiter not sent");
  AST_LINK_UP: assert property (@(posedge i_clk) disable iff (i_rst) // RL3
    $rose(st.link100) |-> $past(st.lock_cnt) == plp_pkg::CW'(LOCK_CYC - 1))
    else $error("link up before lock time");
  AST_LINK_DROP: assert property (@(posedge i_clk) disable iff (i_rst) // RL4
    st.win_cnt == plp_pkg::CW'(WIN_CYC - 1) && !st.seen |=> !st.link100)
    else $error("link kept without idle run");
  AST_PD_HDX: assert property (@(posedge i_clk) disable iff (i_rst) // RL7
    st.pd |-> !st.fdx)
    else $error("parallel detect in full duplex");
  AST_L10_NLP: assert property (@(posedge i_clk) disable iff (i_rst) // RL5
    $rose(st.link10) |-> $past(i_nlp))
    else $error("10M link up without link pulse");
  AST_FIBER_HOLD: assert property (@(posedge i_clk) disable iff (i_rst) // RL9
    st.fib_done |=> $stable(st.fiber))
    else $error("fiber mode changed after reset");
  AST_SD_BLOCK: assert property (@(posedge i_clk) disable iff (i_rst) // RL12
    st.fiber && !i_signal_detect_input |=> !st.rx.dv && !st.link100)
    else $error("fiber data passed under fault");
  AST_FAR_END_FAULT_PATTERN_REPS: assert property (@(posedge i_clk) disable iff (i_rst) // RL14
    st.tx_st == plp_pkg::PLP_TX_FAR_END_FAULT_PATTERN ##1 st.tx_st != plp_pkg::PLP_TX_FAR_END_FAULT_PATTERN
    |-> $past(st.reps) == plp_pkg::FAR_END_FAULT_PATTERN_REPS)
    else $error("fault pattern sent under three times");
  AST_RF_SET: assert property (@(posedge i_clk) disable iff (i_rst) // RL10
    i_lp_page_valid && i_lp_page[plp_pkg::LPA_RF] && st.ctrl[plp_pkg::CTRL_AN_EN] |=> st.rf && st.lpa[plp_pkg::LPA_RF])
    else $error("remote fault not recorded");
endmodule : plp_link_pcs
`default_nettype wire

// ### verif/plp_line_partner.sv
// Line-side partner model: received symbols, lock, signal detect and PLL state.
// Assumes the bench queues frames through push_sym and sets idle and fault levels.
`timescale 1ns/100ps
`default_nettype none
module plp_line_partner (
  input wire logic i_clk,
  input wire logic i_idle_on,
  input wire logic i_fault,
  output logic [4:0] o_rx_sym,
  output logic [6:0] o_drib,
  output logic o_lock,
  output logic o_sd,
  output logic o_pll
);
  logic [11:0] q[$];
  initial begin
    o_rx_sym = 5'h0A;
    o_drib = 7'h00;
    o_lock = 1'b0;
  end
  assign o_sd = ~i_fault;
  assign o_pll = ~i_fault;
  task automatic push_sym(input logic [4:0] s, input logic [6:0] d);
    q.push_back({d, s});
  endtask : push_sym
  // Outside frames: IDLE, or data-like noise that never reads as IDLE or J
  always @(posedge i_clk) begin
    o_lock <= i_idle_on;
    if (q.size() > 0) begin
      {o_drib, o_rx_sym} <= q.pop_front();
    end else begin
      o_drib <= ~o_drib;
      o_rx_sym <= i_idle_on ? plp_pkg::SYM_IDLE : ((o_rx_sym == 5'h0A) ? 5'h15 : 5'h0A);
    end
  end
endmodule : plp_line_partner
`default_nettype wire

// ### verif/plp_link_pcs_tb.sv
// Self-checking bench for plp_link_pcs: register bus, MII and line-side scenarios.
// Assumes the line partner model and shortened link and pulse timers.
`timescale 1ns/100ps
`default_nettype none
module plp_link_pcs_tb;
  localparam int RECOV_CYC = 60000;
  logic i_clk, i_rst, rd_v, wr_v, fsel_n, nlp, lpv, idle_on, fault, an_lk, an_100, an_fdx, rx10dv;
  logic waitr, link, spd, fdx, fib, nrzi, mlt3, nlp_tx, lock, sd, pll;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, rdd;
  logic [15:0] lpg, advp;
  logic [4:0] rsym, tsym;
  logic [6:0] drib;
  plp_pkg::plp_mii_tx_s mtx, tx10;
  plp_pkg::plp_mii_rx_s mrx;
  logic [3:0] rxq[$];
  logic [4:0] txq[$];
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;

  plp_link_pcs #(.LOCK_CYC(50), .WIN_CYC(40), .NLP_CYC(30), .L10_CYC(200)) dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd_v), .i_avs_write(wr_v),
    .i_avs_writedata(wdat), .o_avs_readdata(rdat), .o_avs_waitrequest(waitr), .i_mii_tx(mtx),
    .o_mii_rx(mrx), .i_fiber_select_pin_n(fsel_n), .i_signal_detect_input(sd), .i_rx_pll_lock(pll),
    .i_descr_lock(lock), .i_nlp(nlp), .i_rx_sym(rsym), .i_rx10_dv(rx10dv), .i_rx_dribble(drib[6:4]),
    .i_rx_tail(drib[3:0]), .i_lp_page(lpg), .i_lp_page_valid(lpv), .i_an_link(an_lk), .i_an_100(an_100),
    .i_an_fdx(an_fdx), .o_tx_sym(tsym), .o_tx_nrzi(nrzi), .o_tx_mlt3(mlt3), .o_tx10(tx10),
    .o_nlp_tx(nlp_tx), .o_adv_page(advp), .o_link(link), .o_spd100(spd), .o_fdx(fdx), .o_fiber(fib));
  plp_line_partner partner_u (.i_clk(i_clk), .i_idle_on(idle_on), .i_fault(fault), .o_rx_sym(rsym),
    .o_drib(drib), .o_lock(lock), .o_sd(sd), .o_pll(pll));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // Values seen at each edge are the settled ones from before it
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    txq.push_back(tsym);
    if (mrx.dv === 1'b1) rxq.push_back(mrx.d);
    if (cyc == 70000) begin
      err_total++;
      final_report();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    adr <= a;
    wr_v <= w;
    rd_v <= ~w;
    wdat <= d;
    do @(posedge i_clk); while (waitr !== 1'b0);
    rdd = rdat;
    wr_v <= 1'b0;
    rd_v <= 1'b0;
    @(posedge i_clk);
  endtask : bus
  task automatic do_reset(input logic pin);
    i_rst <= 1'b1;
    fsel_n <= pin;
    tick(2);
    i_rst <= 1'b0;
    tick(2);
    fsel_n <= ~pin;
  endtask : do_reset
  task automatic rx_frame(input logic [6:0] d);
    partner_u.push_sym(plp_pkg::SYM_J, 7'h00);
    partner_u.push_sym(plp_pkg::SYM_K, 7'h00);
    partner_u.push_sym(5'h15, 7'h00);
    partner_u.push_sym(5'h13, 7'h00);
    partner_u.push_sym(plp_pkg::SYM_T, d);
    partner_u.push_sym(plp_pkg::SYM_R, 7'h00);
  endtask : rx_frame
  task automatic final_report;
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    bus(1'b0, 8'h00, 32'h0);
    chk("ctrl", 32'h3000, rdd);
    bus(1'b0, 8'h10, 32'h0);
    chk("adv", 32'h01E1, rdd);
    bus(1'b0, 8'hFC, 32'h0);
    chk("unmapped", 32'h0, rdd);
    bus(1'b1, 8'h10, 32'h21E1);
    bus(1'b1, 8'h00, 32'h3100);
    chk("adv_page", 32'h21E1, advp);
    lpg <= 16'h21E1;
    lpv <= 1'b1;
    tick(1);
    lpv <= 1'b0;
    tick(1);
    bus(1'b0, 8'h14, 32'h0);
    chk("lpa", 32'h21E1, rdd);
    bus(1'b0, 8'h04, 32'h0);
    chk("stat_rf", 1'b1, rdd[4]);
    bus(1'b0, 8'h04, 32'h0);
    chk("stat_rf_clr", 1'b0, rdd[4]);
  endtask : t_regs
  task automatic t_link100;
    // Partner sends plain idles, so descrambling is bypassed
    bus(1'b1, 8'h40, 32'h1000);
    idle_on <= 1'b1;
    tick(40);
    chk("link_early", 1'b0, link);
    tick(30);
    chk("link_up", 1'b1, link);
    chk("spd100", 1'b1, spd);
    chk("half_dup", 1'b0, fdx);
    tick(100);
    chk("link_hold", 1'b1, link);
    bus(1'b0, 8'h44, 32'h0);
    chk("link10", 1'b0, rdd[5]);
    idle_on <= 1'b0;
    tick(100);
    chk("link_drop", 1'b0, link);
  endtask : t_link100
  task automatic t_tx;
    logic [3:0] nb[6];
    logic [4:0] e[9];
    int j;
    nb = '{4'h5, 4'h5, 4'h5, 4'hD, 4'h0, 4'hF};
    e = '{5'h18, 5'h11, 5'h0B, 5'h1B, 5'h1E, 5'h1D, 5'h0D, 5'h07, 5'h1F};
    j = 0;
    bus(1'b1, 8'h40, 32'h5000);
    chk("link_down", 1'b0, link);
    txq.delete();
    for (int i = 0; i < 6; i++) begin
      mtx <= {1'b1, nb[i]};
      tick(1);
    end
    mtx <= '0;
    tick(12);
    for (int i = txq.size() - 1; i >= 0; i--) if (txq[i] === plp_pkg::SYM_J) j = i;
    chk("tx_idle", 5'h1F, txq[0]);
    for (int k = 0; k < 9; k++) chk("tx_sym", e[k], txq[j + k]);
    chk("mlt3", 1'b1, mlt3);
    chk("nrzi_tp", 1'b0, nrzi);
  endtask : t_tx
  task automatic t_rx;
    logic [3:0] e[5];
    e = '{4'h5, 4'h5, 4'h3, 4'h9, 4'hD};
    idle_on <= 1'b1;
    tick(70);
    for (int f = 0; f < 2; f++) begin
      rxq.delete();
      rx_frame((f == 0) ? 7'h21 : 7'h6A);
      tick(12);
      chk("rx_len", 5 - f, rxq.size());
      for (int k = 0; k < rxq.size() && k < 5; k++) chk("rx_nib", e[k], rxq[k]);
    end
  endtask : t_rx
  task automatic t_10m;
    int cnt;
    cnt = 0;
    do_reset(1'b1);
    idle_on <= 1'b0;
    bus(1'b1, 8'h00, 32'h3100);
    for (int i = 0; i < 4; i++) begin
      nlp <= 1'b1;
      tick(1);
      nlp <= 1'b0;
      tick(19);
    end
    chk("spd10", 1'b0, spd);
    chk("half_dup10", 1'b0, fdx);
    chk("link10_up", 1'b1, link);
    mtx <= {1'b1, 4'h6};
    tick(3);
    chk("tx10", 5'h16, tx10);
    chk("tx_sym10", 5'h00, tsym);
    mtx <= '0;
    for (int i = 0; i < 60; i++) begin
      tick(1);
      cnt += int'(nlp_tx);
    end
    chk("nlp_cnt", 1'b1, cnt >= 1 && cnt <= 2);
    rx10dv <= 1'b1;
    tick(2);
    chk("rx10", 2'b11, {mrx.dv, mrx.crs});
    rx10dv <= 1'b0;
    an_lk <= 1'b1;
    an_fdx <= 1'b1;
    tick(2);
    chk("an_spd", 1'b1, spd);
    chk("an_fdx", 1'b1, fdx);
    an_lk <= 1'b0;
  endtask : t_10m
  task automatic t_fiber;
    int n, p, bad;
    n = 0;
    p = 0;
    bad = 0;
    do_reset(1'b0);
    chk("fiber", 1'b1, fib);
    chk("nrzi", 1'b1, nrzi);
    chk("mlt3_fx", 1'b0, mlt3);
    bus(1'b1, 8'h40, 32'h0004);
    idle_on <= 1'b1;
    tick(70);
    chk("fx_link", 1'b1, link);
    txq.delete();
    rxq.delete();
    fault <= 1'b1;
    rx_frame(7'h00);
    tick(2);
    chk("fx_drop", 1'b0, link);
    tick(10);
    fault <= 1'b0;
    tick(70);
    chk("fx_rx_block", 32'h0, rxq.size());
    // Short fault still yields three whole patterns, then plain IDLE
    for (int i = 0; i < txq.size(); i++) begin
      if (txq[i] === 5'h1E) begin
        n++;
        if (n > 1 && i - p != 17) bad++;
        p = i;
      end else if (txq[i] !== 5'h1F) bad++;
    end
    chk("far_end_fault_pattern_reps", 32'h3, n);
    chk("far_end_fault_pattern_shape", 32'h0, bad);
  endtask : t_fiber

  initial begin
    i_rst = 1'b1;
    fsel_n = 1'b1;
    adr = 8'h00;
    rd_v = 1'b0;
    wr_v = 1'b0;
    wdat = 32'h0;
    mtx = '0;
    nlp = 1'b0;
    lpg = 16'h0;
    lpv = 1'b0;
    idle_on = 1'b0;
    fault = 1'b0;
    an_lk = 1'b0;
    an_100 = 1'b1;
    an_fdx = 1'b0;
    rx10dv = 1'b0;
    do_reset(1'b1);
    tick(RECOV_CYC);
    t_regs();
    t_link100();
    t_tx();
    t_rx();
    t_10m();
    t_fiber();
    final_report();
  end
endmodule : plp_link_pcs_tb
`default_nettype wire
